// *** common/dpmt_regs.vh ***
// constants of the memory-and-multiplier tile: port geometry, width codes,
// read-during-write codes and reset values; included by bare name
`ifndef DPMT_REGS_VH
`define DPMT_REGS_VH

// storage: 512 words of 36 bits, 32 data bits and 4 parity bits per word
`define DPMT_DEPTH      512
`define DPMT_WORD_W     36
`define DPMT_IDX_W      9
`define DPMT_ADDR_W     14
`define DPMT_PAR_LSB    32

// port width codes
`define DPMT_W1         3'h0
`define DPMT_W2         3'h1
`define DPMT_W4         3'h2
`define DPMT_W9         3'h3
`define DPMT_W18        3'h4
`define DPMT_W36        3'h5

// read-during-write codes
`define DPMT_RDW_NEW    2'h0
`define DPMT_RDW_OLD    2'h1
`define DPMT_RDW_HOLD   2'h2

// multiplier operand and product widths
`define DPMT_OP_W       18
`define DPMT_PROD_W     36
`define DPMT_SHARED_W   18

// reset values
`define DPMT_DOUT_RST   36'h0
`define DPMT_PROD_RST   36'h0

`endif

// *** hw/dpmt_mul.v ***
// signed 18 x 18 multiplier with a registered 36-bit product
// assumes operands are synchronous to mclk_i; product appears one edge after en_i
`timescale 1ns/100ps
`default_nettype none
`include "dpmt_regs.vh"

module dpmt_mul (
  input  wire                      mclk_i,
  input  wire                      rst_n_i,
  input  wire                      en_i,
  input  wire [`DPMT_OP_W-1:0]     a_i,
  input  wire [`DPMT_OP_W-1:0]     b_i,
  output wire [`DPMT_PROD_W-1:0]   p_o
);

  reg  [`DPMT_PROD_W-1:0] prod_r;
  wire [`DPMT_PROD_W-1:0] prod_nxt;

  // two's-complement operands, full-width product
  assign prod_nxt = $signed(a_i) * $signed(b_i);

  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prod_r <= `DPMT_PROD_RST;
    end else if (en_i) begin
      prod_r <= prod_nxt;
    end
  end

  assign p_o = prod_r;

endmodule // dpmt_mul
`default_nettype wire

// *** hw/dpmt_tile.v ***
// dual-port 18 Kb memory with an associated signed multiplier
// assumes all inputs are synchronous to mclk_i and driven by fabric logic
`timescale 1ns/100ps
`default_nettype none
`include "dpmt_regs.vh"

// Operation
// - the memory holds 18 Kb and each port is set as 16Kx1, 8Kx2, 4Kx4, 2Kx9, 1Kx18 or 512x36.
// - each port works synchronously on its own enable, independently, with three write-read modes.
// - the multiplier takes two signed 18-bit operands and gives the full signed 36-bit product.
// - the multiplier runs from fabric operands whether or not the memory is in use.
// - while the multiplier is in use a port may be at most 18 bits wide; the tile then refuses only 36-wide writes, 36-wide reads still run.
// - read data of a memory port can feed the multiplier directly for multiply-accumulate.
module dpmt_tile (
  input  wire                      mclk_i,
  input  wire                      rst_n_i,
  input  wire                      a_en_i,
  input  wire                      a_we_i,
  input  wire [2:0]                a_width_i,
  input  wire [1:0]                a_rdw_i,
  input  wire [`DPMT_ADDR_W-1:0]   a_addr_i,
  input  wire [`DPMT_WORD_W-1:0]   a_din_i,
  output wire [`DPMT_WORD_W-1:0]   a_dout_o,
  input  wire                      b_en_i,
  input  wire                      b_we_i,
  input  wire [2:0]                b_width_i,
  input  wire [1:0]                b_rdw_i,
  input  wire [`DPMT_ADDR_W-1:0]   b_addr_i,
  input  wire [`DPMT_WORD_W-1:0]   b_din_i,
  output wire [`DPMT_WORD_W-1:0]   b_dout_o,
  input  wire                      mul_en_i,
  input  wire                      mul_a_sel_i,
  input  wire                      mul_b_sel_i,
  input  wire [`DPMT_OP_W-1:0]     mul_a_i,
  input  wire [`DPMT_OP_W-1:0]     mul_b_i,
  output wire [`DPMT_PROD_W-1:0]   mul_p_o,
  output wire                      width_err_o
);

  ////////////////////////////////////////////////////////////////////////////
  // geometry functions

  // word index for a port address at a given width
  function [`DPMT_IDX_W-1:0] dpmt_word;
    input [2:0]              wm;
    input [`DPMT_ADDR_W-1:0] a;
    begin
      case (wm)
        `DPMT_W1:  dpmt_word = a[13:5];
        `DPMT_W2:  dpmt_word = a[12:4];
        `DPMT_W4:  dpmt_word = a[11:3];
        `DPMT_W9:  dpmt_word = a[10:2];
        `DPMT_W18: dpmt_word = a[9:1];
        default:   dpmt_word = a[8:0];
      endcase
    end
  endfunction

  // bits of the word that the access covers; 9/18/36 include parity bits
  function [`DPMT_WORD_W-1:0] dpmt_mask;
    input [2:0]              wm;
    input [`DPMT_ADDR_W-1:0] a;
    begin
      case (wm)
        `DPMT_W1:  dpmt_mask = 36'h1 << a[4:0];
        `DPMT_W2:  dpmt_mask = 36'h3 << {a[3:0], 1'b0};
        `DPMT_W4:  dpmt_mask = 36'hf << {a[2:0], 2'b00};
        `DPMT_W9:  dpmt_mask = (36'hff << {a[1:0], 3'b000})
                             | (36'h1 << (`DPMT_PAR_LSB + a[1:0]));
        `DPMT_W18: dpmt_mask = (36'hffff << {a[0], 4'h0})
                             | (36'h3 << (`DPMT_PAR_LSB + {a[0], 1'b0}));
        default:   dpmt_mask = 36'hfffffffff;
      endcase
    end
  endfunction

  // port data placed in its lanes of the word
  function [`DPMT_WORD_W-1:0] dpmt_align;
    input [2:0]              wm;
    input [`DPMT_ADDR_W-1:0] a;
    input [`DPMT_WORD_W-1:0] d;
    begin
      case (wm)
        `DPMT_W1:  dpmt_align = {35'h0, d[0]} << a[4:0];
        `DPMT_W2:  dpmt_align = {34'h0, d[1:0]} << {a[3:0], 1'b0};
        `DPMT_W4:  dpmt_align = {32'h0, d[3:0]} << {a[2:0], 2'b00};
        `DPMT_W9:  dpmt_align = ({28'h0, d[7:0]} << {a[1:0], 3'b000})
                              | ({35'h0, d[8]} << (`DPMT_PAR_LSB + a[1:0]));
        `DPMT_W18: dpmt_align = ({20'h0, d[15:0]} << {a[0], 4'h0})
                              | ({34'h0, d[17:16]} << (`DPMT_PAR_LSB + {a[0], 1'b0}));
        default:   dpmt_align = d;
      endcase
    end
  endfunction

  // port data taken from its lanes of the word, parity on top
  function [`DPMT_WORD_W-1:0] dpmt_extract;
    input [2:0]              wm;
    input [`DPMT_ADDR_W-1:0] a;
    input [`DPMT_WORD_W-1:0] w;
    reg   [`DPMT_WORD_W-1:0] s;
    reg   [`DPMT_WORD_W-1:0] p;
    begin
      s = w;
      p = w >> `DPMT_PAR_LSB;
      case (wm)
        `DPMT_W1: begin
          s = w >> a[4:0];
          dpmt_extract = {35'h0, s[0]};
        end
        `DPMT_W2: begin
          s = w >> {a[3:0], 1'b0};
          dpmt_extract = {34'h0, s[1:0]};
        end
        `DPMT_W4: begin
          s = w >> {a[2:0], 2'b00};
          dpmt_extract = {32'h0, s[3:0]};
        end
        `DPMT_W9: begin
          s = w >> {a[1:0], 3'b000};
          p = p >> a[1:0];
          dpmt_extract = {27'h0, p[0], s[7:0]};
        end
        `DPMT_W18: begin
          s = w >> {a[0], 4'h0};
          p = p >> {a[0], 1'b0};
          dpmt_extract = {18'h0, p[1:0], s[15:0]};
        end
        default: dpmt_extract = w;
      endcase
    end
  endfunction

  function [`DPMT_WORD_W-1:0] dpmt_merge;
    input [`DPMT_WORD_W-1:0] w;
    input [`DPMT_WORD_W-1:0] m;
    input [`DPMT_WORD_W-1:0] v;
    begin
      dpmt_merge = (w & ~m) | (v & m);
    end
  endfunction

  // next registered read data for one port
  function [`DPMT_WORD_W-1:0] dpmt_rdata;
    input                    en;
    input                    wr;
    input [1:0]              rdw;
    input [2:0]              wm;
    input [`DPMT_ADDR_W-1:0] a;
    input [`DPMT_WORD_W-1:0] oldw;
    input [`DPMT_WORD_W-1:0] neww;
    input [`DPMT_WORD_W-1:0] cur;
    begin
      if (!en) begin
        dpmt_rdata = cur;
      end else if (!wr) begin
        dpmt_rdata = dpmt_extract(wm, a, oldw);
      end else begin
        case (rdw)
          `DPMT_RDW_NEW: dpmt_rdata = dpmt_extract(wm, a, neww);
          `DPMT_RDW_OLD: dpmt_rdata = dpmt_extract(wm, a, oldw);
          default:       dpmt_rdata = cur;
        endcase
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // storage and write path

  reg  [`DPMT_WORD_W-1:0] mem [0:`DPMT_DEPTH-1];
  reg  [`DPMT_WORD_W-1:0] a_dout_r;
  reg  [`DPMT_WORD_W-1:0] b_dout_r;
  wire [`DPMT_WORD_W-1:0] a_dout_nxt;
  wire [`DPMT_WORD_W-1:0] b_dout_nxt;
  wire [`DPMT_IDX_W-1:0]  a_idx;
  wire [`DPMT_IDX_W-1:0]  b_idx;
  wire [`DPMT_WORD_W-1:0] a_mask;
  wire [`DPMT_WORD_W-1:0] b_mask;
  wire [`DPMT_WORD_W-1:0] a_val;
  wire [`DPMT_WORD_W-1:0] b_val;
  wire [`DPMT_WORD_W-1:0] a_old;
  wire [`DPMT_WORD_W-1:0] b_old;
  wire [`DPMT_WORD_W-1:0] a_base;
  wire [`DPMT_WORD_W-1:0] a_fin;
  wire [`DPMT_WORD_W-1:0] b_fin;
  wire                    a_wide;
  wire                    b_wide;
  wire                    a_wr;
  wire                    b_wr;
  wire                    same_word;

  assign a_idx  = dpmt_word(a_width_i, a_addr_i);
  assign b_idx  = dpmt_word(b_width_i, b_addr_i);
  assign a_mask = dpmt_mask(a_width_i, a_addr_i);
  assign b_mask = dpmt_mask(b_width_i, b_addr_i);
  assign a_val  = dpmt_align(a_width_i, a_addr_i, a_din_i);
  assign b_val  = dpmt_align(b_width_i, b_addr_i, b_din_i);
  assign a_old  = mem[a_idx];
  assign b_old  = mem[b_idx];

  // upper data lines are the multiplier operands, so a 36-wide write is refused
  // codes above the 36-wide code map the full word too, so they are refused alike
  assign a_wide      = mul_en_i && (a_width_i >= `DPMT_W36);
  assign b_wide      = mul_en_i && (b_width_i >= `DPMT_W36);
  assign width_err_o = (a_en_i && a_wide) || (b_en_i && b_wide);

  assign a_wr      = a_en_i && a_we_i && !a_wide;
  assign b_wr      = b_en_i && b_we_i && !b_wide;
  assign same_word = (a_idx == b_idx);

  // both ports into one word: port b lanes first, port a wins on overlap
  assign a_base = (same_word && b_wr) ? dpmt_merge(a_old, b_mask, b_val) : a_old;
  assign a_fin  = a_wr ? dpmt_merge(a_base, a_mask, a_val) : a_base;
  assign b_fin  = same_word ? a_fin
                            : (b_wr ? dpmt_merge(b_old, b_mask, b_val) : b_old);

  always @(posedge mclk_i) begin
    if (a_wr) begin
      mem[a_idx] <= a_fin;
    end
    if (b_wr) begin
      mem[b_idx] <= b_fin;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read ports

  assign a_dout_nxt = dpmt_rdata(a_en_i, a_wr, a_rdw_i, a_width_i, a_addr_i,
                                 a_old, a_fin, a_dout_r);
  assign b_dout_nxt = dpmt_rdata(b_en_i, b_wr, b_rdw_i, b_width_i, b_addr_i,
                                 b_old, b_fin, b_dout_r);

  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      a_dout_r <= `DPMT_DOUT_RST;
      b_dout_r <= `DPMT_DOUT_RST;
    end else begin
      a_dout_r <= a_dout_nxt;
      b_dout_r <= b_dout_nxt;
    end
  end

  assign a_dout_o = a_dout_r;
  assign b_dout_o = b_dout_r;

  ////////////////////////////////////////////////////////////////////////////
  // multiplier

  wire [`DPMT_OP_W-1:0] op_a;
  wire [`DPMT_OP_W-1:0] op_b;

  // operands from fabric, or straight from the registered read data
  assign op_a = mul_a_sel_i ? a_dout_r[`DPMT_SHARED_W-1:0] : mul_a_i;
  assign op_b = mul_b_sel_i ? b_dout_r[`DPMT_SHARED_W-1:0] : mul_b_i;

  dpmt_mul u_mul (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .en_i    (mul_en_i),
    .a_i     (op_a),
    .b_i     (op_b),
    .p_o     (mul_p_o)
  );

endmodule // dpmt_tile
`default_nettype wire

// *** testbench/dpmt_acc.sv ***
// fabric accumulator beside the tile: sums each product one edge after use
// assumes vld_i is the multiplier enable seen by the tile
`timescale 1ns/100ps
`default_nettype none
module dpmt_acc (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic        clr_i,
  input  wire logic        vld_i,
  input  wire logic [35:0] p_i,
  output logic      [47:0] acc_o
);
  logic vld_r;
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vld_r <= 1'b0;
      acc_o <= 48'h0;
    end else begin
      vld_r <= vld_i;
      if (clr_i)
        acc_o <= 48'h0;
      else if (vld_r)
        acc_o <= acc_o + {{12{p_i[35]}}, p_i};
    end
  end
endmodule // dpmt_acc
`default_nettype wire

// *** testbench/dpmt_tile_properties.sv ***
// checker on the tile ports: product, hold, width flag, read modes
// assumes one clock mclk_i and the active-low reset rst_n_i
`timescale 1ns/100ps
`default_nettype none
module dpmt_tile_chk (
  input wire logic        mclk_i,
  input wire logic        rst_n_i,
  input wire logic        a_en_i,
  input wire logic        a_we_i,
  input wire logic [2:0]  a_width_i,
  input wire logic [1:0]  a_rdw_i,
  input wire logic [35:0] a_din_i,
  input wire logic [35:0] a_dout_o,
  input wire logic        b_en_i,
  input wire logic [2:0]  b_width_i,
  input wire logic        mul_en_i,
  input wire logic        mul_a_sel_i,
  input wire logic        mul_b_sel_i,
  input wire logic [17:0] mul_a_i,
  input wire logic [17:0] mul_b_i,
  input wire logic [35:0] mul_p_o,
  input wire logic        width_err_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  mul_prod_a: assert property (mul_en_i && !mul_a_sel_i && !mul_b_sel_i |=>
    $signed(mul_p_o) == $signed($past(mul_a_i)) * $signed($past(mul_b_i)))
    else $error("product mismatch");
  prod_hold_a: assert property (!mul_en_i |=> $stable(mul_p_o))
    else $error("product moved while idle");
  width_flag_a: assert property (width_err_o == (mul_en_i &&
    ((a_en_i && a_width_i >= 3'h5) || (b_en_i && b_width_i >= 3'h5))))
    else $error("width flag wrong");
  idle_hold_a: assert property (!a_en_i |=> $stable(a_dout_o))
    else $error("read data moved while idle");
  rdw_hold_a: assert property (a_en_i && a_we_i && a_rdw_i >= 2'h2 &&
    !(mul_en_i && a_width_i >= 3'h5) |=> $stable(a_dout_o))
    else $error("hold mode changed output");
  rdw_new_a: assert property (a_en_i && a_we_i && a_rdw_i == 2'h0 &&
    a_width_i == 3'h5 && !mul_en_i |=> a_dout_o == $past(a_din_i))
    else $error("new data mode wrong");
  mac_feed_a: assert property (mul_en_i && mul_a_sel_i && !mul_b_sel_i |=>
    $signed(mul_p_o) == $signed($past(a_dout_o[17:0])) * $signed($past(mul_b_i)))
    else $error("memory operand product wrong");
  narrow_zero_a: assert property (a_en_i && !a_we_i && a_width_i == 3'h4 |=>
    a_dout_o[35:18] == 18'h0)
    else $error("upper read bits not zero");
  cover property (mul_en_i && mul_a_sel_i);
  cover property (width_err_o);
  cover property (a_en_i && a_we_i && a_rdw_i == 2'h1);
endmodule // dpmt_tile_chk
bind dpmt_tile dpmt_tile_chk i_dpmt_tile_chk (.mclk_i, .rst_n_i, .a_en_i, .a_we_i,
  .a_width_i, .a_rdw_i, .a_din_i, .a_dout_o, .b_en_i, .b_width_i, .mul_en_i,
  .mul_a_sel_i, .mul_b_sel_i, .mul_a_i, .mul_b_i, .mul_p_o, .width_err_o);
`default_nettype wire

// *** testbench/dpmt_tile_tb.sv ***
// self-checking bench of the tile with a fabric accumulator
// assumes inputs change at the falling edge of mclk_i
`timescale 1ns/100ps
`default_nettype none
module dpmt_tile_tb;
  logic mclk_i = 0, rst_n_i = 0, a_en_i = 0, a_we_i = 0, b_en_i = 0, b_we_i = 0;
  logic mul_en_i = 0, mul_a_sel_i = 0, mul_b_sel_i = 0, acc_clr = 0;
  logic [2:0]  a_width_i = 0, b_width_i = 0;
  logic [1:0]  a_rdw_i = 0, b_rdw_i = 0;
  logic [13:0] a_addr_i = 0, b_addr_i = 0;
  logic [35:0] a_din_i = 0, b_din_i = 0, word0 = 36'h9a5c3e71b;
  logic [17:0] mul_a_i = 0, mul_b_i = 0;
  wire logic [35:0] a_dout_o, b_dout_o, mul_p_o;
  wire logic        width_err_o;
  wire logic [47:0] acc;
  int err_count = 0, checks_done = 0, cyc = 0;
  logic        hi_sel = 0, hi_q = 0;
  wire logic [35:0] hi_dout, casc_dout;
  dpmt_tile i_dpmt_tile (.mclk_i, .rst_n_i, .a_en_i(a_en_i && !hi_sel), .a_we_i, .a_width_i,
    .a_rdw_i,
    .a_addr_i, .a_din_i, .a_dout_o, .b_en_i, .b_we_i, .b_width_i, .b_rdw_i, .b_addr_i,
    .b_din_i, .b_dout_o, .mul_en_i, .mul_a_sel_i, .mul_b_sel_i, .mul_a_i, .mul_b_i,
    .mul_p_o, .width_err_o);
  dpmt_acc i_dpmt_acc (.mclk_i, .rst_n_i, .clr_i(acc_clr), .vld_i(mul_en_i),
    .p_i(mul_p_o), .acc_o(acc));
  // second tile above the first: enable decode by hi_sel, registered data select
  dpmt_tile i_dpmt_tile_hi (.mclk_i, .rst_n_i, .a_en_i(a_en_i && hi_sel), .a_we_i, .a_width_i,
    .a_rdw_i, .a_addr_i, .a_din_i, .a_dout_o(hi_dout), .b_en_i(1'b0), .b_we_i(1'b0),
    .b_width_i(3'h0), .b_rdw_i(2'h0), .b_addr_i(14'h0), .b_din_i(36'h0), .b_dout_o(),
    .mul_en_i(1'b0), .mul_a_sel_i(1'b0), .mul_b_sel_i(1'b0), .mul_a_i(18'h0),
    .mul_b_i(18'h0), .mul_p_o(), .width_err_o());
  always @(posedge mclk_i) begin
    if (a_en_i)
      hi_q <= hi_sel;
  end
  assign casc_dout = hi_q ? hi_dout : a_dout_o;
  ////////////////////////////////////////
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic opa(input logic we, input logic [2:0] w, input logic [1:0] m,
                     input logic [13:0] ad, input logic [35:0] d);
    a_en_i = 1'b1;
    a_we_i = we;
    a_width_i = w;
    a_rdw_i = m;
    a_addr_i = ad;
    a_din_i = d;
    @(negedge mclk_i);
  endtask
  // port stays enabled after opa, so back-to-back requests never toggle the enable
  task automatic a_off;
    a_en_i = 1'b0;
    a_we_i = 1'b0;
    @(negedge mclk_i);
  endtask
  function automatic logic [35:0] view(input logic [2:0] w, input logic [35:0] v);
    case (w)
      3'h0: view = {35'h0, v[1]};
      3'h1: view = {34'h0, v[3:2]};
      3'h2: view = {32'h0, v[7:4]};
      3'h3: view = {27'h0, v[33], v[15:8]};
      3'h4: view = {18'h0, v[35:34], v[31:16]};
      default: view = v;
    endcase
  endfunction
  ////////////////////////////////////////
  task automatic t_width;
    opa(1'b1, 3'h5, 2'h0, 14'h3, word0);
    chk(a_dout_o, word0);
    a_off();
    b_en_i = 1'b1;
    for (int w = 0; w < 6; w++) begin
      b_width_i = w[2:0];
      b_addr_i = (14'h3 << (5 - w)) | 14'(w != 5);
      @(negedge mclk_i);
      chk(b_dout_o, view(w[2:0], word0));
    end
    b_en_i = 1'b0;
    $display("t_width done");
  endtask
  task automatic t_rdw;
    logic [35:0] nv;
    for (int m = 0; m < 3; m++) begin
      nv = 36'h25a5a + m;
      opa(1'b1, 3'h4, 2'h0, 14'h10, 36'h11234);
      opa(1'b1, 3'h4, 2'h0, 14'h12, 36'h00777);
      opa(1'b1, 3'h4, m[1:0], 14'h10, nv);
      chk(a_dout_o, m == 0 ? nv : m == 1 ? 36'h11234 : 36'h00777);
      opa(1'b0, 3'h4, 2'h0, 14'h10, 36'h0);
      chk(a_dout_o, nv);
    end
    a_off();
    $display("t_rdw done");
  endtask
  task automatic t_mul;
    logic signed [17:0] av [4] = '{-18'sd3, 18'sh20000, 18'sh1ffff, 18'sh20000};
    logic signed [17:0] bv [4] = '{18'sd5, 18'sh20000, -18'sd1, 18'sh1ffff};
    logic signed [35:0] ex;
    for (int i = 0; i < 4; i++) begin
      mul_en_i = 1'b1;
      mul_a_i = av[i];
      mul_b_i = bv[i];
      @(negedge mclk_i);
      mul_en_i = 1'b0;
      mul_a_i = 18'h0;
      @(negedge mclk_i);
      ex = av[i] * bv[i];
      chk(mul_p_o, ex);
    end
    $display("t_mul done");
  endtask
  task automatic t_refuse;
    mul_en_i = 1'b1;
    a_en_i = 1'b1;
    a_we_i = 1'b1;
    a_width_i = 3'h5;
    a_addr_i = 14'h3;
    a_din_i = 36'h0;
    #1;
    chk({35'h0, width_err_o}, 36'h1);
    @(negedge mclk_i);
    a_en_i = 1'b0;
    a_we_i = 1'b0;
    mul_en_i = 1'b0;
    chk(a_dout_o, word0);
    $display("t_refuse done");
  endtask
  task automatic t_mac;
    logic signed [17:0] cf [4] = '{18'sd7, -18'sd300, 18'sd1000, -18'sd2};
    logic signed [17:0] xv [4] = '{-18'sd9, 18'sd41, 18'sd123, -18'sd500};
    logic signed [47:0] sum;
    sum = 48'sh0;
    acc_clr = 1'b1;
    @(negedge mclk_i);
    acc_clr = 1'b0;
    for (int i = 0; i < 4; i++)
      opa(1'b1, 3'h4, 2'h0, 14'h20 + 14'(i), {18'h0, cf[i]});
    mul_a_sel_i = 1'b1;
    for (int i = 0; i < 4; i++) begin
      opa(1'b0, 3'h4, 2'h0, 14'h20 + 14'(i), 36'h0);
      mul_en_i = 1'b1;
      mul_b_i = xv[i];
      @(negedge mclk_i);
      mul_en_i = 1'b0;
      sum = sum + cf[i] * xv[i];
    end
    repeat (2) @(negedge mclk_i);
    mul_a_sel_i = 1'b0;
    chk(acc[35:0], sum[35:0]);
    a_off();
    $display("t_mac done");
  endtask
  task automatic t_reset;
    rst_n_i = 1'b0;
    #1;
    chk(a_dout_o, 36'h0);
    chk(b_dout_o, 36'h0);
    chk(mul_p_o, 36'h0);
    @(negedge mclk_i);
    rst_n_i = 1'b1;
    opa(1'b0, 3'h5, 2'h0, 14'h3, 36'h0);
    chk(a_dout_o, word0);
    a_off();
    $display("t_reset done");
  endtask
  task automatic t_casc;
    hi_sel = 1'b1;
    opa(1'b1, 3'h5, 2'h0, 14'h3, 36'h6b1d2e4f7);
    opa(1'b0, 3'h5, 2'h0, 14'h3, 36'h0);
    chk(casc_dout, 36'h6b1d2e4f7);
    hi_sel = 1'b0;
    opa(1'b0, 3'h5, 2'h0, 14'h3, 36'h0);
    chk(casc_dout, word0);
    a_off();
    $display("t_casc done");
  endtask
  ////////////////////////////////////////
  initial begin
    forever #5 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      end_sim();
    end
  end
  initial begin
    repeat (12) @(posedge mclk_i);
    @(negedge mclk_i);
    rst_n_i = 1'b1;
    t_width();
    t_rdw();
    t_mul();
    t_reset();
    t_refuse();
    t_mac();
    t_casc();
    end_sim();
  end
endmodule // dpmt_tile_tb
`default_nettype wire
